// ===== rtl/synth_ctrl_status_regs.sv
// register slice: general output control, slip prevention, temperature and status
// assumes the serial port decoder delivers word writes and combinational read address;
// analog status inputs come from other clock domains and are synchronised here
`timescale 1ns/1ps
module synth_ctrl_status_regs #(
   parameter int TEMP_W = 7
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire synth_regs_pkg::reg_req_t req,
   output logic [23:0] rdata,
   input wire logic reg1_bit15,
   input wire logic [2:0] quant_lsbs,
   input wire logic slip_auto_rst_n,
   input wire logic lock_raw,
   input wire logic [2:0] overflow_raw,
   input wire logic sweep_raw,
   input wire logic [6:0] temp_code_raw,
   output logic [2:0] gpo_out,
   output logic [2:0] gpo_oe,
   output synth_regs_pkg::pfd_ctrl_t pfd_ctrl,
   output logic charge_pump_hiz,
   output logic temp_sensor_en
);
   logic [23:0] gpo_ctrl_q, gpo_ctrl_d;
   logic [23:0] slip_ctrl_q, slip_ctrl_d;
   logic [23:0] rsvd_a_q, rsvd_a_d;
   logic [23:0] tsens_ctrl_q, tsens_ctrl_d;
   logic [2:0] gpo_out_q;
   logic [2:0] gpo_oe_q;
   logic [5:0] stat_s1_q, stat_s2_q;
   logic [6:0] temp_s1_q, temp_s2_q;
   logic [6:0] temp_q;

   // write decode
   wire wr_gpo = req.wr_en && req.addr == synth_regs_pkg::OFF_OUTPUT_PIN_CTRL;
   wire wr_slip = req.wr_en && req.addr == synth_regs_pkg::OFF_SLIP_PREVENTION_CTRL;
   wire wr_rsvd_a = req.wr_en && req.addr == synth_regs_pkg::OFF_RESERVED_WORD_A;
   wire wr_tsens = req.wr_en && req.addr == synth_regs_pkg::OFF_TEMP_SENSOR_CTRL;

   // writable words; read-only offsets have no write strobe at all
   assign gpo_ctrl_d = wr_gpo ? req.wdata : gpo_ctrl_q;
   assign slip_ctrl_d = wr_slip ? req.wdata : slip_ctrl_q;
   assign rsvd_a_d = wr_rsvd_a ? req.wdata : rsvd_a_q;
   assign tsens_ctrl_d = wr_tsens ? req.wdata : tsens_ctrl_q;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         gpo_ctrl_q <= synth_regs_pkg::RST_OUTPUT_PIN_CTRL;
         slip_ctrl_q <= synth_regs_pkg::RST_SLIP_PREVENTION_CTRL;
         rsvd_a_q <= synth_regs_pkg::RST_RESERVED_WORD_A;
         tsens_ctrl_q <= synth_regs_pkg::RST_TEMP_SENSOR_CTRL;
      end else begin
         gpo_ctrl_q <= gpo_ctrl_d;
         slip_ctrl_q <= slip_ctrl_d;
         rsvd_a_q <= rsvd_a_d;
         tsens_ctrl_q <= tsens_ctrl_d;
      end
   end

   // output source mux and driver enables
   wire [3:0] gpo_sel = gpo_ctrl_q[synth_regs_pkg::GPO_SEL_LSB +: 4];
   wire [2:0] gpo_static = gpo_ctrl_q[synth_regs_pkg::GPO_DATA_LSB +: 3];
   wire gpo_drv_en = gpo_ctrl_q[synth_regs_pkg::GPO_DRV_EN_BIT];
   wire [2:0] gpo_dis = gpo_ctrl_q[synth_regs_pkg::GPO_DIS_LSB +: 3];
   // other source codes route signals outside this slice; those read as zero here
   wire [2:0] gpo_src = (gpo_sel == synth_regs_pkg::SEL_STATIC) ? gpo_static :
                        (gpo_sel == synth_regs_pkg::SEL_QUANT) ? quant_lsbs :
                        3'h0;
   wire [2:0] gpo_oe_d = {3{gpo_drv_en}} & ~gpo_dis;

   // quantizer bits are same-domain logic, registered once for clean pads
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         gpo_out_q <= 3'h0;
         gpo_oe_q <= 3'h0;
      end else begin
         gpo_out_q <= gpo_src;
         gpo_oe_q <= gpo_oe_d;
      end
   end
   assign gpo_out = gpo_out_q;
   assign gpo_oe = gpo_oe_q;

   // phase detector controls
   wire [3:0] step = slip_ctrl_q[synth_regs_pkg::SLIP_STEP_LSB +: 4];
   wire rst_force = slip_ctrl_q[synth_regs_pkg::SLIP_FORCE_BIT];
   wire rst_manual = slip_ctrl_q[synth_regs_pkg::SLIP_RSTB_BIT];
   wire pfd_rst_n = rst_force ? rst_manual : slip_auto_rst_n;
   assign pfd_ctrl.step_count = step;
   // feature needs nonzero step, manual enable and the register 1 companion bit
   assign pfd_ctrl.slip_prevention_en = (step != 4'h0) && rst_manual && reg1_bit15;
   assign pfd_ctrl.pfd_rst_n = pfd_rst_n;
   // a held detector reset floats the pump; software should leave override clear
   assign charge_pump_hiz = !pfd_rst_n;
   assign temp_sensor_en = tsens_ctrl_q[synth_regs_pkg::TSENS_EN_BIT];

   // status inputs come from analog domains, two flops before use
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         stat_s1_q <= 6'h00;
         stat_s2_q <= 6'h00;
         temp_s1_q <= 7'h00;
         temp_s2_q <= 7'h00;
         temp_q <= 7'h00;
      end else begin
         stat_s1_q <= {sweep_raw, 1'b0, overflow_raw, lock_raw};
         stat_s2_q <= stat_s1_q;
         temp_s1_q <= temp_code_raw;
         temp_s2_q <= temp_s1_q;
         temp_q <= sat_temp(temp_s2_q);
      end
   end

   // clamp to the top code; sensor already quantizes in 17.5 degree steps
   function automatic logic [6:0] sat_temp(input logic [6:0] c);
      sat_temp = (c > synth_regs_pkg::TEMP_CODE_MAX) ? synth_regs_pkg::TEMP_CODE_MAX : c;
   endfunction : sat_temp

   // read mux; unmapped offsets read zero
   always_comb begin
      case (req.addr)
         synth_regs_pkg::OFF_OUTPUT_PIN_CTRL: rdata = gpo_ctrl_q;
         synth_regs_pkg::OFF_SLIP_PREVENTION_CTRL: rdata = slip_ctrl_q;
         synth_regs_pkg::OFF_RESERVED_WORD_A: rdata = rsvd_a_q;
         synth_regs_pkg::OFF_TEMP_SENSOR_CTRL: rdata = tsens_ctrl_q;
         synth_regs_pkg::OFF_LOCK_SWEEP_STATUS: rdata = {18'h0, stat_s2_q};
         synth_regs_pkg::OFF_RESERVED_WORD_B: rdata = synth_regs_pkg::RST_RESERVED_WORD_B;
         synth_regs_pkg::OFF_TEMP_READOUT: rdata = {17'h0, temp_q};
         synth_regs_pkg::OFF_RESERVED_WORD_C: rdata = synth_regs_pkg::RST_RESERVED_WORD_C;
         default: rdata = 24'h000000;
      endcase
   end

   // checks
   property p_quant_route;
      @(posedge clk_sys) disable iff (!rst_n)
      gpo_sel == synth_regs_pkg::SEL_QUANT |=> gpo_out == $past(quant_lsbs);
   endproperty
   a_quant_route: assert property (p_quant_route) else $error("quantizer route wrong");

   property p_static_route;
      @(posedge clk_sys) disable iff (!rst_n)
      gpo_sel == 4'h0 |=> gpo_out == $past(gpo_static);
   endproperty
   a_static_route: assert property (p_static_route) else $error("static route wrong");

   property p_global_off;
      @(posedge clk_sys) disable iff (!rst_n)
      !gpo_drv_en |=> gpo_oe == 3'h0;
   endproperty
   a_global_off: assert property (p_global_off) else $error("pads driven while off");

   property p_ind_dis;
      @(posedge clk_sys) disable iff (!rst_n)
      gpo_drv_en |=> gpo_oe == ~$past(gpo_dis);
   endproperty
   a_ind_dis: assert property (p_ind_dis) else $error("individual disable wrong");

   property p_step_zero;
      @(posedge clk_sys) disable iff (!rst_n)
      step == 4'h0 |-> !pfd_ctrl.slip_prevention_en;
   endproperty
   a_step_zero: assert property (p_step_zero) else $error("slip enabled at zero step");

   property p_override;
      @(posedge clk_sys) disable iff (!rst_n)
      wr_slip && req.wdata[synth_regs_pkg::SLIP_FORCE_BIT] |=>
         pfd_ctrl.pfd_rst_n == $past(req.wdata[synth_regs_pkg::SLIP_RSTB_BIT]);
   endproperty
   a_override: assert property (p_override) else $error("override ignored");

   property p_hiz;
      @(posedge clk_sys) disable iff (!rst_n)
      charge_pump_hiz |-> !pfd_ctrl.pfd_rst_n;
   endproperty
   a_hiz: assert property (p_hiz) else $error("pump not tied to reset");

   property p_lock_lat;
      @(posedge clk_sys) disable iff (!rst_n)
      stat_s2_q[synth_regs_pkg::LOCK_BIT] == $past(lock_raw, 2);
   endproperty
   a_lock_lat: assert property (p_lock_lat) else $error("lock not seen");

   property p_temp_sat;
      @(posedge clk_sys) disable iff (!rst_n)
      temp_q <= synth_regs_pkg::TEMP_CODE_MAX;
   endproperty
   a_temp_sat: assert property (p_temp_sat) else $error("readout over range");

   // reserved word reads its fixed image whatever the host wrote
   property p_ro_hold;
      @(posedge clk_sys) disable iff (!rst_n)
      req.addr == synth_regs_pkg::OFF_RESERVED_WORD_B |-> rdata == synth_regs_pkg::RST_RESERVED_WORD_B;
   endproperty
   a_ro_hold: assert property (p_ro_hold) else $error("read-only word changed");

   property p_rsvd_c_const;
      @(posedge clk_sys) disable iff (!rst_n)
      req.addr == synth_regs_pkg::OFF_RESERVED_WORD_C |-> rdata == synth_regs_pkg::RST_RESERVED_WORD_C;
   endproperty
   a_rsvd_c_const: assert property (p_rsvd_c_const) else $error("reserved word moved");

   // writes aimed at the status and temperature readout offsets must not leak into the output, slip or sensor words
   property p_ro_no_store;
      @(posedge clk_sys) disable iff (!rst_n)
      req.wr_en && (req.addr == synth_regs_pkg::OFF_LOCK_SWEEP_STATUS ||
         req.addr == synth_regs_pkg::OFF_TEMP_READOUT) |=>
         $stable(gpo_ctrl_q) && $stable(slip_ctrl_q) && $stable(tsens_ctrl_q);
   endproperty
   a_ro_no_store: assert property (p_ro_no_store) else $error("read-only write stored");

   // pads come out of reset quiet
   property p_reset_outputs;
      @(posedge clk_sys) disable iff (!rst_n)
      $past(rst_n) == 1'b0 |-> gpo_oe == 3'h0 && gpo_out == 3'h0;
   endproperty
   a_reset_outputs: assert property (p_reset_outputs) else $error("pads live after reset");

   // codes outside this slice must not leak stale data onto the pads
   property p_other_src_zero;
      @(posedge clk_sys) disable iff (!rst_n)
      gpo_sel != synth_regs_pkg::SEL_STATIC && gpo_sel != synth_regs_pkg::SEL_QUANT |=>
         gpo_out == 3'h0;
   endproperty
   a_other_src_zero: assert property (p_other_src_zero) else $error("unrouted code drives");

   property p_dis_each;
      @(posedge clk_sys) disable iff (!rst_n)
      gpo_dis != 3'h0 |=> (gpo_oe & $past(gpo_dis)) == 3'h0;
   endproperty
   a_dis_each: assert property (p_dis_each) else $error("disabled pad still driven");

   property p_all_on;
      @(posedge clk_sys) disable iff (!rst_n)
      gpo_drv_en && gpo_dis == 3'h0 |=> gpo_oe == 3'h7;
   endproperty
   a_all_on: assert property (p_all_on) else $error("pad driver missing");

   property p_gpo_write;
      @(posedge clk_sys) disable iff (!rst_n)
      wr_gpo |=> gpo_ctrl_q == $past(req.wdata);
   endproperty
   a_gpo_write: assert property (p_gpo_write) else $error("output control not stored");

   property p_gpo_hold;
      @(posedge clk_sys) disable iff (!rst_n)
      !wr_gpo |=> $stable(gpo_ctrl_q);
   endproperty
   a_gpo_hold: assert property (p_gpo_hold) else $error("output control drifted");

   // detector reset source selection, both arms
   property p_auto_rst;
      @(posedge clk_sys) disable iff (!rst_n)
      !rst_force |-> pfd_ctrl.pfd_rst_n == slip_auto_rst_n;
   endproperty
   a_auto_rst: assert property (p_auto_rst) else $error("automatic reset not followed");

   property p_manual_rst;
      @(posedge clk_sys) disable iff (!rst_n)
      rst_force |-> pfd_ctrl.pfd_rst_n == rst_manual;
   endproperty
   a_manual_rst: assert property (p_manual_rst) else $error("manual reset not followed");

   property p_hiz_exact;
      @(posedge clk_sys) disable iff (!rst_n)
      !pfd_ctrl.pfd_rst_n |-> charge_pump_hiz;
   endproperty
   a_hiz_exact: assert property (p_hiz_exact) else $error("pump driving in reset");

   property p_slip_en;
      @(posedge clk_sys) disable iff (!rst_n)
      pfd_ctrl.slip_prevention_en |-> rst_manual && reg1_bit15;
   endproperty
   a_slip_en: assert property (p_slip_en) else $error("slip enabled without bits");

   property p_slip_on;
      @(posedge clk_sys) disable iff (!rst_n)
      step != 4'h0 && rst_manual && reg1_bit15 |-> pfd_ctrl.slip_prevention_en;
   endproperty
   a_slip_on: assert property (p_slip_on) else $error("slip prevention missing");

   property p_slip_write;
      @(posedge clk_sys) disable iff (!rst_n)
      wr_slip |=> pfd_ctrl.step_count == $past(req.wdata[3:0]);
   endproperty
   a_slip_write: assert property (p_slip_write) else $error("step count not stored");

   property p_tsens_en;
      @(posedge clk_sys) disable iff (!rst_n)
      wr_tsens |=> temp_sensor_en == $past(req.wdata[synth_regs_pkg::TSENS_EN_BIT]);
   endproperty
   a_tsens_en: assert property (p_tsens_en) else $error("sensor enable not stored");

   property p_tsens_hold;
      @(posedge clk_sys) disable iff (!rst_n)
      !wr_tsens |=> $stable(temp_sensor_en);
   endproperty
   a_tsens_hold: assert property (p_tsens_hold) else $error("sensor enable drifted");

   // status latency is exactly the two synchroniser flops
   property p_ovf_lat;
      @(posedge clk_sys) disable iff (!rst_n)
      stat_s2_q[synth_regs_pkg::OVF_LSB +: 3] == $past(overflow_raw, 2);
   endproperty
   a_ovf_lat: assert property (p_ovf_lat) else $error("overflow flags wrong");

   property p_sweep_lat;
      @(posedge clk_sys) disable iff (!rst_n)
      stat_s2_q[synth_regs_pkg::SWEEP_BIT] == $past(sweep_raw, 2);
   endproperty
   a_sweep_lat: assert property (p_sweep_lat) else $error("sweep flag wrong");

   property p_temp_pass;
      @(posedge clk_sys) disable iff (!rst_n)
      temp_s2_q <= synth_regs_pkg::TEMP_CODE_MAX |=> temp_q == $past(temp_s2_q);
   endproperty
   a_temp_pass: assert property (p_temp_pass) else $error("readout code altered");

   property p_temp_clamp;
      @(posedge clk_sys) disable iff (!rst_n)
      temp_s2_q > synth_regs_pkg::TEMP_CODE_MAX |=> temp_q == synth_regs_pkg::TEMP_CODE_MAX;
   endproperty
   a_temp_clamp: assert property (p_temp_clamp) else $error("readout not clamped");

   // main scenarios worth seeing at least once
   c_quant: cover property (@(posedge clk_sys) gpo_sel == synth_regs_pkg::SEL_QUANT && gpo_oe != 0);
   c_static: cover property (@(posedge clk_sys) gpo_sel == synth_regs_pkg::SEL_STATIC && gpo_oe == 3'h7);
   c_clamp: cover property (@(posedge clk_sys) temp_q == synth_regs_pkg::TEMP_CODE_MAX);
   c_force: cover property (@(posedge clk_sys) charge_pump_hiz);
   c_slip: cover property (@(posedge clk_sys) pfd_ctrl.slip_prevention_en);
endmodule : synth_ctrl_status_regs

// ===== rtl/synth_regs_pkg.sv
// constants, field positions and carriers for the synthesizer register slice
// assumes a 24-bit register word reached through a documented word-wide port
package synth_regs_pkg;
   localparam int DATA_W = 24;
   localparam int ADDR_W = 8;
   // register offsets, printed offsets are word indices
   localparam logic [7:0] OFF_OUTPUT_PIN_CTRL = 8'h1B;
   localparam logic [7:0] OFF_SLIP_PREVENTION_CTRL = 8'h1C;
   localparam logic [7:0] OFF_RESERVED_WORD_A = 8'h1D;
   localparam logic [7:0] OFF_TEMP_SENSOR_CTRL = 8'h1E;
   localparam logic [7:0] OFF_LOCK_SWEEP_STATUS = 8'h1F;
   localparam logic [7:0] OFF_RESERVED_WORD_B = 8'h20;
   localparam logic [7:0] OFF_TEMP_READOUT = 8'h21;
   localparam logic [7:0] OFF_RESERVED_WORD_C = 8'h22;
   // output control fields
   localparam int GPO_SEL_LSB = 0;
   localparam int GPO_DATA_LSB = 4;
   localparam int GPO_DRV_EN_BIT = 7;
   localparam int GPO_DIS_LSB = 8;
   localparam logic [3:0] SEL_STATIC = 4'h0;
   localparam logic [3:0] SEL_QUANT = 4'hA;
   // slip prevention fields
   localparam int SLIP_STEP_LSB = 0;
   localparam int SLIP_FORCE_BIT = 4;
   localparam int SLIP_RSTB_BIT = 5;
   // status fields and sensor enable bit
   localparam int LOCK_BIT = 0;
   localparam int OVF_LSB = 1;
   localparam int SWEEP_BIT = 5;
   localparam int TSENS_EN_BIT = 0;
   // reset values
   localparam logic [23:0] RST_OUTPUT_PIN_CTRL = 24'h000000;
   localparam logic [23:0] RST_SLIP_PREVENTION_CTRL = 24'h000020;
   localparam logic [23:0] RST_RESERVED_WORD_A = 24'h000000;
   localparam logic [23:0] RST_TEMP_SENSOR_CTRL = 24'h000000;
   localparam logic [23:0] RST_RESERVED_WORD_B = 24'h000020;
   localparam logic [23:0] RST_RESERVED_WORD_C = 24'h000000;
   // temperature readout saturation
   localparam logic [6:0] TEMP_CODE_MAX = 7'h07;
   // host register access carrier
   typedef struct packed {
      logic wr_en;
      logic [7:0] addr;
      logic [23:0] wdata;
   } reg_req_t;
   // phase detector control carrier
   typedef struct packed {
      logic [3:0] step_count;
      logic pfd_rst_n;
      logic slip_prevention_en;
   } pfd_ctrl_t;
endpackage : synth_regs_pkg

// ===== dv/host_port_model.sv
// host controller on the word-wide register port of the synthesizer slice
// assumes the caller runs at falling edges of clk_sys; reads are combinational on addr
`timescale 1ns/1ps
module host_port_model (
   input wire logic clk_sys,
   output synth_regs_pkg::reg_req_t req
);
   initial req = '0;
   // one write: strobe raised off-edge and held across exactly one rising edge
   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      @(negedge clk_sys);
      req = '{wr_en: 1'h1, addr: a, wdata: d};
      @(negedge clk_sys);
      req.wr_en = 1'h0;
   endtask : wr
   // read: only the address moves, the bench samples rdata while it holds
   task automatic rd_addr(input logic [7:0] a);
      req.addr = a;
   endtask : rd_addr
   // sensor use: enable first, then the start strobe in the base word
   task automatic tsens_start();
      wr(8'h1E, 24'h000001);
      wr(8'h00, 24'h000008);
   endtask : tsens_start
endmodule : host_port_model

// ===== dv/synth_ctrl_status_regs_test.sv
// self-checking bench for the output, slip prevention, sensor and status slice
// assumes the host model drives the port; status inputs are treated as async levels
`timescale 1ns/1ps
module synth_ctrl_status_regs_test;
   logic clk_sys = 1'h0;
   logic rst_n = 1'h0;
   synth_regs_pkg::reg_req_t req;
   synth_regs_pkg::pfd_ctrl_t pfd_ctrl;
   logic [23:0] rdata, obs, d, w;
   logic [2:0] quant_lsbs = 3'h0, overflow_raw = 3'h0, gpo_out, gpo_oe, eo;
   logic [6:0] temp_code_raw = 7'h00;
   logic reg1_bit15 = 1'h0, slip_auto_rst_n = 1'h1, lock_raw = 1'h0, sweep_raw = 1'h0;
   logic charge_pump_hiz, temp_sensor_en, rn;
   logic [23:0] exp_q[$];
   int sel, failures, samples_checked;
   int tv[5] = '{0, 6, 7, 8, 127};
   event chk;
   always #2 clk_sys = ~clk_sys;
   host_port_model host (.clk_sys(clk_sys), .req(req));
   synth_ctrl_status_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .rdata(rdata),
      .reg1_bit15(reg1_bit15), .quant_lsbs(quant_lsbs), .slip_auto_rst_n(slip_auto_rst_n),
      .lock_raw(lock_raw), .overflow_raw(overflow_raw), .sweep_raw(sweep_raw),
      .temp_code_raw(temp_code_raw), .gpo_out(gpo_out), .gpo_oe(gpo_oe), .pfd_ctrl(pfd_ctrl),
      .charge_pump_hiz(charge_pump_hiz), .temp_sensor_en(temp_sensor_en));
   // observed value picked by the pending check
   assign obs = (sel == 0) ? rdata : (sel == 1) ? {18'h0, gpo_oe, gpo_out} :
      (sel == 2) ? {17'h0, pfd_ctrl, charge_pump_hiz} : {23'h0, temp_sensor_en};
   // monitor: oldest note against what the outputs show now
   always @(chk) begin
      logic [23:0] e;
      e = exp_q.pop_front();
      samples_checked++;
      if (obs !== e) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, obs, e);
      end
   end
   // note one expectation at a falling edge; addr also set for register reads
   task automatic expect_val(input int s, input logic [7:0] a, input logic [23:0] e);
      @(negedge clk_sys);
      host.rd_addr(a);
      sel = s;
      exp_q.push_back(e);
      #1 ->chk;
   endtask : expect_val
   task automatic complete_run();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   // watchdog so a hang still reaches the verdict
   initial begin
      #100000;
      failures++;
      complete_run();
   end
   // main sequence
   initial begin
      void'($urandom(40435));
      repeat (2) @(negedge clk_sys);
      rst_n = 1'h1;
      // reset image, unmapped neighbours read zero
      for (int a = 8'h1A; a <= 8'h23; a++)
         expect_val(0, a[7:0], (a == 8'h1C || a == 8'h20) ? 24'h000020 : 24'h0);
      expect_val(1, 8'h00, 24'h0);
      // output routing and pad enables; code 3 stands for an unrouted source
      for (int k = 0; k < 24; k++) begin
         d = 24'($urandom);
         @(negedge clk_sys);
         quant_lsbs = d[13:11];
         w = {13'h0, d[10:4], (k % 3 == 0) ? 4'h0 : (k % 3 == 1) ? 4'hA : 4'h3};
         host.wr(8'h1B, w);
         eo = (w[3:0] == 4'h0) ? d[6:4] : (w[3:0] == 4'hA) ? d[13:11] : 3'h0;
         expect_val(1, 8'h1B, {18'h0, d[7] ? ~d[10:8] : 3'h0, eo});
         expect_val(0, 8'h1B, w);
      end
      // detector reset source, slip enable and charge pump state
      for (int k = 0; k < 24; k++) begin
         d = 24'($urandom);
         @(negedge clk_sys);
         reg1_bit15 = d[8];
         slip_auto_rst_n = d[9];
         host.wr(8'h1C, {18'h0, d[5:0]});
         rn = d[4] ? d[5] : d[9];
         expect_val(2, 8'h1C, {17'h0, d[3:0], rn, (d[3:0] != 4'h0) & d[5] & d[8], ~rn});
      end
      host.tsens_start();
      expect_val(3, 8'h00, 24'h000001);
      // readout codes including both range ends and the top clamp point
      foreach (tv[i]) begin
         @(negedge clk_sys);
         temp_code_raw = tv[i][6:0];
         repeat (3) @(negedge clk_sys);
         expect_val(0, 8'h21, (tv[i] > 7) ? 24'h000007 : tv[i][23:0]);
      end
      // status flags, then writes to read-only words must leave them alone
      for (int k = 0; k < 8; k++) begin
         d = 24'($urandom);
         @(negedge clk_sys);
         {sweep_raw, overflow_raw, lock_raw} = {d[5], d[3:0]};
         repeat (3) @(negedge clk_sys);
         host.wr(8'h1F, 24'hFFFFFF);
         host.wr(8'h20, 24'h000000);
         expect_val(0, 8'h1F, {18'h0, d[5], 1'h0, d[3:0]});
         expect_val(0, 8'h20, 24'h000020);
         expect_val(0, 8'h21, 24'h000007);
      end
      repeat (2) @(negedge clk_sys);
      complete_run();
   end
endmodule : synth_ctrl_status_regs_test
